/* File: design/cgs_pkg.sv */
// Constants shared by the clock generation block
package cgs_pkg;
   // ==========================================================
   // Reset configuration word field layout
   localparam int unsigned SYSTEM_PLL_MULTIPLIER_LSB = 24;
   localparam int unsigned SYSTEM_PLL_MULTIPLIER_W = 4;
   localparam int unsigned CORE_LSB = 16;
   localparam int unsigned CORE_W = 7;
   localparam int unsigned MEMORY_CLOCK_MODE_BIT = 30;
   localparam int unsigned LOCAL_BUS_CLOCK_MODE_BIT = 31;
   localparam int unsigned CFG_W = 32;
   // ==========================================================
   // Counts and widths
   localparam int unsigned NUM_BUS_OUT = 5;
   localparam int unsigned NUM_UNITS = 5;
   localparam int unsigned NUM_LCLK = 3;
   localparam int unsigned NUM_PINS = 3;
   localparam int unsigned PIN_HOST = 0;
   localparam int unsigned PIN_PCI = 1;
   localparam int unsigned PIN_FB = 2;
   localparam logic [2:0] LOCK_WINDOW = 3'h7;
   localparam logic [5:0] LOCK_BASE = 6'h08;
   localparam logic [5:0] LOCK_TOL = 6'h01;
   localparam logic [5:0] REF_COUNT_MAX = 6'h3F;
   // ==========================================================
   // Unit ratio codes
   typedef enum logic [1:0] {
      RATIO_OFF   = 2'h0,
      RATIO_FULL  = 2'h1,
      RATIO_HALF  = 2'h2,
      RATIO_THIRD = 2'h3
   } cgs_ratio_t;
   localparam logic [1:0] RATIO_RESET = 2'h3;
   localparam logic [1:0] PERIOD_FULL = 2'h0;
   localparam logic [1:0] PERIOD_HALF = 2'h1;
   localparam logic [1:0] PERIOD_THIRD = 2'h2;
   // ==========================================================
   // Local bus divide field codes, half period minus one in unit ticks
   localparam logic [1:0] LDIV_2 = 2'h0;
   localparam logic [1:0] LDIV_4 = 2'h1;
   localparam logic [2:0] LHALF_2 = 3'h0;
   localparam logic [2:0] LHALF_4 = 3'h1;
   localparam logic [2:0] LHALF_8 = 3'h3;
endpackage

/* File: design/cgs_unit_divider.sv */
// Per-unit clock enable divider with boundary-aligned ratio changes
`timescale 1ns/100ps
module cgs_unit_divider (
   input  wire logic       clock,     // System clock
   input  wire logic       rstn,      // Async reset, active low
   input  wire logic       csbTick,   // System bus clock enable
   input  wire logic [1:0] ratio,     // Requested ratio code
   output logic            unitTick   // Unit clock enable pulse
);
   logic [1:0] countReg;
   logic [1:0] countNext;
   logic       tickNext;
   logic       atBoundary;
   logic [1:0] periodLoad;

   assign atBoundary = (countReg == 2'h0);
   assign periodLoad =
      (ratio == cgs_pkg::RATIO_HALF)  ? cgs_pkg::PERIOD_HALF  :
      (ratio == cgs_pkg::RATIO_THIRD) ? cgs_pkg::PERIOD_THIRD :
                                        cgs_pkg::PERIOD_FULL;
   // New ratio only loads when a period completes, never mid-pulse
   assign countNext = !csbTick ? countReg :
                      atBoundary ? periodLoad : countReg - 2'h1;
   assign tickNext = csbTick && atBoundary &&
                     (ratio != cgs_pkg::RATIO_OFF);

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         countReg <= 2'h0;
         unitTick <= 1'b0;
      end else begin
         countReg <= countNext;
         unitTick <= tickNext;
      end
   end
endmodule

/* File: design/cgs_clock_gen.sv */
// Clock selection, derivation and unit gating for the system clock block
`timescale 1ns/100ps
// How it works
// - Host mode uses host reference input
// - Agent mode uses bus clock input
// - Host reference halved; strap picks sync output
// - Each bus clock output has own enable
// - Lock tracked against sync feedback input
// - Host reference equals feedback times strap factor
// - PLL multipliers taken from reset config word
// - Memory clock from mode bit, halved out
// - Memory data rate equals internal memory clock
// - Local bus unit clock from mode bit
// - Units start at default ratio, reprogrammable; no reset default held here, unitRatio ports supply the ratio
// - Five unit groups default third, four options; third not built in, each ratio comes straight from unitRatio
// - Second I2C clock fixed, not configurable
// - Local bus clock half, quarter or eighth
module cgs_clock_gen (
   input  wire logic        clock,               // 25 MHz clock
   input  wire logic        rstn,                // Async reset, low
   input  wire logic        hostModeStrap,       // 1 = bus host
   input  wire logic        ref_divider_strap,   // Sync out divide select
   input  wire logic [31:0] reset_config_word_low, // Config word straps
   input  wire logic        host_ref_clock_in,   // Host reference pin
   input  wire logic        busClockIn,          // Bus clock pin
   input  wire logic        syncFeedbackIn,      // Sync feedback pin
   input  wire logic [4:0]  bus_clock_out_enable, // Per-output enables
   input  wire logic [1:0]  local_bus_divide_field, // Local bus ratio
   input  wire logic [9:0]  unitRatio,           // Two bits per unit
   input  wire logic        pciDmaOn,            // PCI/DMA group on
   output logic             syncOut,             // Sync output pin
   output logic [4:0]       bus_clock_out_n,     // Bus clock outputs
   output logic [3:0]       system_pll_multiplier, // System multiplier
   output logic [6:0]       core_pll_multiplier, // Core multiplier
   output logic             refLocked,           // Feedback lock
   output logic             memory_bus_clock_out,   // Memory clock
   output logic             memoryBusClockOutN,  // Memory clock inverse
   output logic             memDataTick,         // Memory data enable
   output logic [2:0]       local_bus_clock_outs, // Local bus clocks
   output logic [4:0]       unitClockTick,       // Unit clock enables
   output logic             pciDmaTick,          // PCI/DMA enable
   output logic             i2cSecondTick,       // Second I2C enable
   output logic             csbTickOut           // System bus enable
);
   // ==========================================================
   // Pin synchronisers
   logic [2:0] sync1Reg;
   logic [2:0] sync2Reg;
   logic [2:0] sync3Reg;
   logic [2:0] pinReg;
   logic [2:0] pinPrevReg;
   logic [2:0] pinRise;
   logic [2:0] pinIn;

   // Filter assumes pins slower than a quarter of the block clock
   assign pinIn[cgs_pkg::PIN_HOST] = host_ref_clock_in;
   assign pinIn[cgs_pkg::PIN_PCI]  = busClockIn;
   assign pinIn[cgs_pkg::PIN_FB]   = syncFeedbackIn;

   genvar gi;
   generate
      for (gi = 0; gi < cgs_pkg::NUM_PINS; gi++) begin : gPin
         always_ff @(posedge clock or negedge rstn) begin
            if (!rstn) begin
               sync1Reg[gi]   <= 1'b0;
               sync2Reg[gi]   <= 1'b0;
               sync3Reg[gi]   <= 1'b0;
               pinReg[gi]     <= 1'b0;
               pinPrevReg[gi] <= 1'b0;
            end else begin
               sync1Reg[gi] <= pinIn[gi];
               sync2Reg[gi] <= sync1Reg[gi];
               sync3Reg[gi] <= sync2Reg[gi];
               if (sync2Reg[gi] == sync3Reg[gi])
                  pinReg[gi] <= sync3Reg[gi];
               pinPrevReg[gi] <= pinReg[gi];
            end
         end
         assign pinRise[gi] = pinReg[gi] && !pinPrevReg[gi];
      end
   endgenerate

   // ==========================================================
   // Strap capture after reset release
   logic        capturedReg;
   logic        hostModeReg;
   logic        refDivReg;
   logic        ddrModeReg;
   logic        lbModeReg;
   logic [3:0]  sysMultField;
   logic [6:0]  coreMultField;

   assign sysMultField = reset_config_word_low[
      cgs_pkg::SYSTEM_PLL_MULTIPLIER_LSB +: cgs_pkg::SYSTEM_PLL_MULTIPLIER_W];
   assign coreMultField = reset_config_word_low[
      cgs_pkg::CORE_LSB +: cgs_pkg::CORE_W];

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         capturedReg           <= 1'b0;
         hostModeReg           <= 1'b0;
         refDivReg             <= 1'b0;
         ddrModeReg            <= 1'b0;
         lbModeReg             <= 1'b0;
         system_pll_multiplier <= 4'h0;
         core_pll_multiplier   <= 7'h00;
      end else if (!capturedReg) begin
         capturedReg           <= 1'b1;
         hostModeReg           <= hostModeStrap;
         refDivReg             <= ref_divider_strap;
         ddrModeReg            <= reset_config_word_low[cgs_pkg::MEMORY_CLOCK_MODE_BIT];
         lbModeReg             <= reset_config_word_low[cgs_pkg::LOCAL_BUS_CLOCK_MODE_BIT];
         system_pll_multiplier <= sysMultField;
         core_pll_multiplier   <= coreMultField;
      end
   end

   // ==========================================================
   // Primary reference select and sync output
   logic       primaryLevel;
   logic       primaryRise;
   logic       halfReg;
   logic       halfNext;
   logic       syncNext;

   assign primaryLevel = hostModeReg ? pinReg[cgs_pkg::PIN_HOST]
                                     : pinReg[cgs_pkg::PIN_PCI];
   assign primaryRise = hostModeReg ? pinRise[cgs_pkg::PIN_HOST]
                                    : pinRise[cgs_pkg::PIN_PCI];
   assign halfNext = primaryRise ? !halfReg : halfReg;
   // Agent mode passes the bus clock straight through
   assign syncNext = (hostModeReg && refDivReg) ? halfReg
                                                : primaryLevel;

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         halfReg <= 1'b0;
         syncOut <= 1'b0;
      end else begin
         halfReg <= halfNext;
         syncOut <= syncNext;
      end
   end

   // One flop per bus clock output, each behind its own enable
   generate
      for (gi = 0; gi < cgs_pkg::NUM_BUS_OUT; gi++) begin : gBusOut
         always_ff @(posedge clock or negedge rstn) begin
            if (!rstn)
               bus_clock_out_n[gi] <= 1'b0;
            else
               bus_clock_out_n[gi] <= bus_clock_out_enable[gi] &&
                                      syncNext;
         end
      end
   endgenerate

   // ==========================================================
   // Lock check: reference edges per feedback window
   logic [2:0] fbCountReg;
   logic [2:0] fbCountNext;
   logic [5:0] refCountReg;
   logic [5:0] refCountNext;
   logic [5:0] expected;
   logic [5:0] lowBound;
   logic [5:0] highBound;
   logic       windowEnd;
   logic       refSaturated;
   logic       inWindow;
   logic       lockedNext;

   // Expected count tracks reference = feedback times (1 + strap) in host mode, times 1 in agent mode
   assign expected = (hostModeReg && refDivReg) ?
                     {cgs_pkg::LOCK_BASE[4:0], 1'b0}
                     : cgs_pkg::LOCK_BASE;
   assign lowBound = expected - cgs_pkg::LOCK_TOL;
   assign highBound = expected + cgs_pkg::LOCK_TOL;
   assign windowEnd = pinRise[cgs_pkg::PIN_FB] &&
                      (fbCountReg == cgs_pkg::LOCK_WINDOW);
   assign fbCountNext = pinRise[cgs_pkg::PIN_FB] ? fbCountReg + 3'h1
                                                 : fbCountReg;
   // Saturate so a runaway reference cannot wrap into the window
   assign refSaturated = (refCountReg == cgs_pkg::REF_COUNT_MAX);
   assign inWindow = (refCountReg >= lowBound) &&
                     (refCountReg <= highBound);
   assign lockedNext = windowEnd ? inWindow : refLocked;
   // An edge on the window end opens the next window's count
   assign refCountNext =
      windowEnd ? {5'h00, primaryRise} :
      (primaryRise && !refSaturated) ? refCountReg + 6'h01 :
                                       refCountReg;

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         fbCountReg  <= 3'h0;
         refCountReg <= 6'h00;
         refLocked   <= 1'b0;
      end else begin
         fbCountReg  <= fbCountNext;
         refCountReg <= refCountNext;
         refLocked   <= lockedNext;
      end
   end

   // ==========================================================
   // System bus, memory and local bus clocks
   // System bus clock runs at half the block clock as an enable
   logic       csbTickReg;
   logic       ddrTick;
   logic       lbiuTick;
   logic       memClockNext;
   logic [2:0] lbCountReg;
   logic [2:0] lbCountNext;
   logic [2:0] lbHalfLoad;
   logic       lbToggle;
   logic [2:0] lbClockNext;

   assign ddrTick = ddrModeReg | csbTickReg;
   assign lbiuTick = lbModeReg | csbTickReg;
   assign memClockNext = ddrTick ? !memory_bus_clock_out
                                 : memory_bus_clock_out;
   assign lbHalfLoad =
      (local_bus_divide_field == cgs_pkg::LDIV_2) ? cgs_pkg::LHALF_2 :
      (local_bus_divide_field == cgs_pkg::LDIV_4) ? cgs_pkg::LHALF_4 :
                                                    cgs_pkg::LHALF_8;
   assign lbToggle = lbiuTick && (lbCountReg == 3'h0);
   // Divide changes only land on a half-period boundary
   assign lbCountNext = lbToggle ? lbHalfLoad :
                        lbiuTick ? lbCountReg - 3'h1 : lbCountReg;
   assign lbClockNext = lbToggle ? ~local_bus_clock_outs
                                 : local_bus_clock_outs;

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         csbTickReg    <= 1'b0;
         csbTickOut    <= 1'b0;
         i2cSecondTick <= 1'b0;
      end else begin
         csbTickReg    <= !csbTickReg;
         csbTickOut    <= csbTickReg;
         i2cSecondTick <= csbTickReg;
      end
   end

   // Memory pair stays complementary from its first edge
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         memory_bus_clock_out <= 1'b0;
         memoryBusClockOutN   <= 1'b1;
         memDataTick          <= 1'b0;
      end else begin
         memory_bus_clock_out <= memClockNext;
         memoryBusClockOutN   <= !memClockNext;
         memDataTick          <= ddrTick;
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn)
         lbCountReg <= 3'h0;
      else
         lbCountReg <= lbCountNext;
   end

   // Three local bus outputs, identical, each its own flop
   generate
      for (gi = 0; gi < cgs_pkg::NUM_LCLK; gi++) begin : gLclk
         always_ff @(posedge clock or negedge rstn) begin
            if (!rstn)
               local_bus_clock_outs[gi] <= 1'b0;
            else
               local_bus_clock_outs[gi] <= lbClockNext[gi];
         end
      end
   endgenerate

   // ==========================================================
   // Per-unit clock ratios
   logic [1:0] pciRatio;

   // Reset value comes from the control ports; software holds third
   generate
      for (gi = 0; gi < cgs_pkg::NUM_UNITS; gi++) begin : gUnit
         cgs_unit_divider uDiv (
            .clock    (clock),
            .rstn     (rstn),
            .csbTick  (csbTickReg),
            .ratio    (unitRatio[2*gi +: 2]),
            .unitTick (unitClockTick[gi])
         );
      end
   endgenerate

   // Group has no divided rate: only full or off
   assign pciRatio = pciDmaOn ? cgs_pkg::RATIO_FULL
                              : cgs_pkg::RATIO_OFF;

   cgs_unit_divider uPciDiv (
      .clock    (clock),
      .rstn     (rstn),
      .csbTick  (csbTickReg),
      .ratio    (pciRatio),
      .unitTick (pciDmaTick)
   );
endmodule

/* File: test/cgs_clock_gen_checker.sv */
// Port assertions for the clock generation block
`timescale 1ns/100ps
module cgs_clock_gen_checker (
   input wire logic        clock,                 // Clock
   input wire logic        rstn,                  // Reset
   input wire logic [31:0] reset_config_word_low, // Straps
   input wire logic [4:0]  bus_clock_out_enable,  // Enables
   input wire logic [9:0]  unitRatio,             // Ratios
   input wire logic        pciDmaOn,              // Group on
   input wire logic        syncOut,               // Sync
   input wire logic [4:0]  bus_clock_out_n,       // Bus clocks
   input wire logic [3:0]  system_pll_multiplier, // System mult
   input wire logic [6:0]  core_pll_multiplier,   // Core mult
   input wire logic        memory_bus_clock_out,  // Memory clock
   input wire logic        memoryBusClockOutN,    // Inverse
   input wire logic [4:0]  unitClockTick,         // Unit pulses
   input wire logic        pciDmaTick,            // Group pulse
   input wire logic        i2cSecondTick          // I2C2 pulse
);
   // ==========================================================
   // Helpers; steady checks wait seven edges after each release
   logic [2:0] age;
   logic       memMode;
   wire        first = age == 3'h0;
   wire        settled = age == 3'h7;
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         age <= 3'h0;
         memMode <= 1'b0;
      end else begin
         age <= settled ? age : age + 3'h1;
         memMode <= first ? reset_config_word_low[cgs_pkg::MEMORY_CLOCK_MODE_BIT]
                          : memMode;
      end
   end
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rstn);
   chk_cfg_capture: assert property (first |=>
      system_pll_multiplier == $past(reset_config_word_low[27:24]) &&
      core_pll_multiplier == $past(reset_config_word_low[22:16]))
      else $error("multipliers not from config word");
   chk_mult_hold: assert property (!first |=>
      $stable(system_pll_multiplier) && $stable(core_pll_multiplier))
      else $error("multipliers changed after capture");
   chk_bus_enable: assert property (settled |-> bus_clock_out_n ==
      ({5{syncOut}} & $past(bus_clock_out_enable)))
      else $error("bus clock output ignores its enable");
   chk_i2c_fixed: assert property (settled |->
      i2cSecondTick != $past(i2cSecondTick)) else $error("I2C2 rate moved");
   chk_pci_full: assert property ((settled && pciDmaOn) [*6] |->
      pciDmaTick != $past(pciDmaTick)) else $error("group not at full rate");
   chk_pci_off: assert property ((settled && !pciDmaOn) [*6] |->
      !pciDmaTick) else $error("group pulse while off");
   chk_unit_off: assert property (
      (settled && unitRatio[1:0] == 2'h0) [*8]
      ##1 (unitRatio[1:0] == 2'h0) [*4] |-> !unitClockTick[0])
      else $error("unit pulse while off");
   chk_unit_full: assert property (
      (settled && unitRatio[1:0] == 2'h1) [*8]
      ##1 (unitRatio[1:0] == 2'h1) [*4] |->
      unitClockTick[0] != $past(unitClockTick[0])) else $error("unit not full");
   chk_mem_rate: assert property (settled |-> memory_bus_clock_out !=
      (memMode ? $past(memory_bus_clock_out) : $past(memory_bus_clock_out, 2)))
      else $error("memory clock rate wrong");
   chk_mem_diff: assert property (settled |->
      memoryBusClockOutN == !memory_bus_clock_out) else $error("memory pair");
   cover property (settled && unitClockTick[4]);
   cover property (settled && memMode && pciDmaTick);
   cover property (settled && |bus_clock_out_n);
endmodule

/* File: test/cgs_board_model.sv */
// Board model: reference oscillators and sync loopback trace
`timescale 1ns/100ps
module cgs_board_model (
   input  wire logic hostMode,          // Host oscillator fitted
   input  wire logic breakLoop,         // Miswired feedback
   input  wire logic syncOut,           // Device sync output
   output logic      host_ref_clock_in, // Host reference pin
   output logic      busClockIn,        // Bus clock pin
   output logic      syncFeedbackIn     // Sync feedback pin
);
   // ==========================================================
   // Oscillators, both far slower than a quarter of the block clock
   logic hostOsc = 1'b0;
   logic busOsc = 1'b0;
   always #200 hostOsc = !hostOsc;
   always #400 busOsc = !busOsc;
   assign host_ref_clock_in = hostMode & hostOsc;
   assign busClockIn = busOsc;
   assign syncFeedbackIn = breakLoop ? busOsc : syncOut;
endmodule

/* File: test/test_cgs_clock_gen.sv */
// Self-checking bench for the clock generation block
`timescale 1ns/100ps
module test_cgs_clock_gen;
   // ==========================================================
   // Stimulus, outputs and bench model state
   logic        clock = 1'b0;
   logic        rstn = 1'b0;
   logic        hostModeStrap = 1'b1;
   logic        ref_divider_strap = 1'b0;
   logic        pciDmaOn = 1'b1;
   logic        breakLoop = 1'b0;
   logic [31:0] reset_config_word_low = 32'h0;
   logic [4:0]  bus_clock_out_enable = 5'h1F;
   logic [1:0]  local_bus_divide_field = 2'h0;
   logic [9:0]  unitRatio = 10'h3FF;
   logic        host_ref_clock_in, busClockIn, syncFeedbackIn, syncOut;
   logic        refLocked, memory_bus_clock_out, memoryBusClockOutN;
   logic        memDataTick, pciDmaTick, i2cSecondTick, csbTickOut;
   logic [4:0]  bus_clock_out_n, unitClockTick;
   logic [3:0]  system_pll_multiplier;
   logic [6:0]  core_pll_multiplier;
   logic [2:0]  local_bus_clock_outs;
   logic [31:0] seed = 32'h924922B1;
   logic [31:0] r, cfg;
   logic [7:0]  lvl;
   int          cnt [16];
   int          es;
   int          n_errors = 0;
   int          num_checks = 0;
   assign lvl = {bus_clock_out_n, syncOut, local_bus_clock_outs[0],
                 memory_bus_clock_out};
   always #20 clock = !clock;
   cgs_clock_gen cgs_clock_gen_i (.clock, .rstn, .hostModeStrap,
      .ref_divider_strap, .reset_config_word_low, .host_ref_clock_in,
      .busClockIn, .syncFeedbackIn, .bus_clock_out_enable,
      .local_bus_divide_field, .unitRatio, .pciDmaOn, .syncOut,
      .bus_clock_out_n, .system_pll_multiplier, .core_pll_multiplier,
      .refLocked, .memory_bus_clock_out, .memoryBusClockOutN, .memDataTick,
      .local_bus_clock_outs, .unitClockTick, .pciDmaTick, .i2cSecondTick,
      .csbTickOut);
   cgs_board_model cgs_board_model_i (.hostMode(hostModeStrap), .breakLoop,
      .syncOut, .host_ref_clock_in, .busClockIn, .syncFeedbackIn);
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task automatic check_bits(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected at %0t: got %0h exp %0h", $time, got, exp);
      end
   endtask
   task automatic check_cnt(input int got, input int exp);
      check_bits(32'(got), 32'(exp));
   endtask
   // Rises, toggles and pulses seen over n cycles, sampled mid-cycle
   task automatic count(input int n);
      logic [7:0] p;
      cnt = '{default: 0};
      p = lvl;
      repeat (n) begin
         @(negedge clock);
         r[15:0] = {lvl[7:2] & ~p[7:2], lvl[1] ^ p[1], memDataTick,
                    lvl[0] ^ p[0], i2cSecondTick, pciDmaTick, unitClockTick};
         p = lvl;
         for (int i = 0; i < 16; i++) cnt[i] += r[i];
      end
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   initial begin
      for (int k = 0; k < 4; k++) begin
         @(negedge clock);
         rstn = 1'b0;
         hostModeStrap = k != 2;
         ref_divider_strap = k == 1;
         breakLoop = k == 3;
         cfg = xs();
         cfg[31:30] = k[1:0];
         reset_config_word_low = cfg;
         bus_clock_out_enable = cfg[4:0] ^ cfg[12:8];
         repeat (4) @(negedge clock);
         rstn = 1'b1;
         @(negedge clock);
         reset_config_word_low = xs();
         check_bits(system_pll_multiplier, cfg[27:24]);
         check_bits(core_pll_multiplier, cfg[22:16]);
         repeat (600) @(negedge clock);
         count(200);
         es = (k == 1 || k == 2) ? 10 : 20;
         check_cnt(cnt[10], es);
         for (int i = 0; i < 5; i++) begin
            check_cnt(cnt[11 + i], bus_clock_out_enable[i] ? es : 0);
         end
         check_bits(refLocked, k != 3);
         for (int d = 0; d < 4; d++) begin
            local_bus_divide_field = d[1:0];
            repeat (20) @(negedge clock);
            count(48);
            check_cnt(cnt[7], k[0] ? 48 : 24);
            check_cnt(cnt[8], k[0] ? 48 : 24);
            es = 48 / ((k[1] ? 1 : 2) << (d > 1 ? 2 : d));
            check_cnt(cnt[9], es);
         end
         $display("clock config %0d done", k);
      end
      for (int i = 0; i < 7; i++) begin
         cfg = xs();
         if (i > 0) begin
            unitRatio = {cfg[9:2], 2'(i - 1)};
            pciDmaOn = i[0];
         end
         repeat (12) @(negedge clock);
         count(60);
         for (int u = 0; u < 5; u++) begin
            es = unitRatio[2 * u +: 2];
            check_cnt(cnt[u], es ? 30 / es : 0);
         end
         check_cnt(cnt[5], pciDmaOn ? 30 : 0);
         check_cnt(cnt[6], 30);
         cfg[0] = csbTickOut;
         @(negedge clock);
         check_bits(csbTickOut, !cfg[0]);
      end
      $display("unit ratio test done");
      end_sim();
   end
   initial begin
      // About 4800 cycles expected; allow twice that
      #400000;
      n_errors++;
      end_sim();
   end
endmodule
bind cgs_clock_gen cgs_clock_gen_checker cgs_clock_gen_checker_i (.clock,
   .rstn, .reset_config_word_low, .bus_clock_out_enable, .unitRatio,
   .pciDmaOn, .syncOut, .bus_clock_out_n, .system_pll_multiplier,
   .core_pll_multiplier, .memory_bus_clock_out, .memoryBusClockOutN,
   .unitClockTick, .pciDmaTick, .i2cSecondTick);
